// *** rtl/cotpwm_pkg.sv ***
// Purpose: constants for the constant-on-time pwm core
// Assumes: 10 MHz clk_sys, digital stand-ins for analog quantities
// Notes: voltages in mV, on-time factor K in ns
// Overview of operation
// - minimum off interval after each high pulse
// - fire only when comparator, limit, timer agree
// - on-time is K times (fb+75mV) over vin
// - select levels map to K 5/3.3/1.8/1.0 us
// - regulate to code, trim limited to 8 percent
// - offset only in deep sleep, 200mV limit
// - offset is signed plus minus minus difference
// - forced pwm when not suspended nor sleeping
// - forced pwm: low side complements high side
// - suspend or deep sleep gives pulse skipping
// - forced pwm during voltage and mode changes
// - hold forced pwm 30 slew clocks after code
// - slew clock 320kHz*47k over resistor value
package cotpwm_pkg;
    localparam int clk_mhz = 10;
    localparam int min_off_ns = 400;
    localparam int min_off_cyc = (min_off_ns * clk_mhz + 999) / 1000;
    localparam int drop_mv = 75;
    localparam int k_vcc_ns = 5000;
    localparam int k_open_ns = 3300;
    localparam int k_ref_ns = 1800;
    localparam int k_gnd_ns = 1000;
    localparam int trim_pct = 8;
    localparam int offset_lim_mv = 200;
    localparam int settle_slew_cyc = 30;
    localparam int slew_base_khz = 320;
    localparam int slew_ref_ohm = 47000;
    localparam int mv_w = 12;
    localparam int ton_w = 16;
    localparam logic [1:0] sel_gnd = 2'h0;
    localparam logic [1:0] sel_ref = 2'h1;
    localparam logic [1:0] sel_open = 2'h2;
    localparam logic [1:0] sel_vcc = 2'h3;
    typedef enum logic [1:0] {
        cotpwm_idle_t_s = 2'b00,
        cotpwm_on_s = 2'b01,
        cotpwm_off_s = 2'b10
    } cotpwm_state_t;
endpackage

// *** rtl/cotpwm_core.sv ***
// Purpose: constant-on-time pulse controller, digital model
// Assumes: analog levels given as mV codes; pins pass 3-flop filters
// Notes: on-time is computed in cycles of clk_sys
`timescale 1ns/1ps
module cotpwm_core #(
    parameter int slew_res_default = 47000
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic error_comp,
    input wire logic current_limit,
    input wire logic [1:0] on_time_select,
    input wire logic suspend_request,
    input wire logic deep_sleep_n,
    input wire logic [cotpwm_pkg::mv_w-1:0] feedback_sense,
    input wire logic [cotpwm_pkg::mv_w-1:0] vin_mv,
    input wire logic [cotpwm_pkg::mv_w-1:0] voltage_code,
    input wire logic signed [cotpwm_pkg::mv_w-1:0] trim_request,
    input wire logic [cotpwm_pkg::mv_w-1:0] offset_plus_input,
    input wire logic [cotpwm_pkg::mv_w-1:0] offset_minus_input,
    input wire logic [19:0] slew_clock_resistor,
    input wire logic code_step,
    output logic high_side_drive,
    output logic low_side_drive,
    output logic skip_mode,
    output logic [cotpwm_pkg::mv_w-1:0] target_mv,
    output logic slew_tick
);
    import cotpwm_pkg::*;

    // three-flop filters on asynchronous level pins
    logic [2:0] s_ec, s_cl, s_sus, s_dsn;
    logic [2:0] next_s_ec, next_s_cl, next_s_sus, next_s_dsn;
    logic ec_q, cl_q, sus_q, dsn_q;
    logic next_ec_q, next_cl_q, next_sus_q, next_dsn_q;

    always_comb
    begin
        next_s_ec = {s_ec[1:0], error_comp};
        next_s_cl = {s_cl[1:0], current_limit};
        next_s_sus = {s_sus[1:0], suspend_request};
        next_s_dsn = {s_dsn[1:0], deep_sleep_n};
        // only stages two and three are compared
        next_ec_q = (s_ec[1] == s_ec[2]) ? s_ec[2] : ec_q;
        next_cl_q = (s_cl[1] == s_cl[2]) ? s_cl[2] : cl_q;
        next_sus_q = (s_sus[1] == s_sus[2]) ? s_sus[2] : sus_q;
        next_dsn_q = (s_dsn[1] == s_dsn[2]) ? s_dsn[2] : dsn_q;
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_ec <= 3'h7;
            s_cl <= 3'h0;
            s_sus <= 3'h0;
            s_dsn <= 3'h7;
            ec_q <= 1'b1;
            cl_q <= 1'b0;
            sus_q <= 1'b0;
            dsn_q <= 1'b1;
        end
        else
        begin
            s_ec <= next_s_ec;
            s_cl <= next_s_cl;
            s_sus <= next_s_sus;
            s_dsn <= next_s_dsn;
            ec_q <= next_ec_q;
            cl_q <= next_cl_q;
            sus_q <= next_sus_q;
            dsn_q <= next_dsn_q;
        end
    end

    function automatic int k_of(input logic [1:0] sel);
        case (sel)
            sel_vcc: k_of = k_vcc_ns;
            sel_open: k_of = k_open_ns;
            sel_ref: k_of = k_ref_ns;
            default: k_of = k_gnd_ns;
        endcase
    endfunction

    function automatic int clampi(input int v, input int lim);
        if (v > lim)
            clampi = lim;
        else if (v < -lim)
            clampi = -lim;
        else
            clampi = v;
    endfunction

    // on-time in clk cycles; divide is costly but keeps feed-forward exact
    logic [ton_w-1:0] ton_cyc;
    always_comb
    begin
        int num;
        int den;
        int q;
        num = k_of(on_time_select) * (int'(feedback_sense) + drop_mv);
        den = (vin_mv == '0) ? 1 : int'(vin_mv);
        q = (num / den) * clk_mhz / 1000;
        if (q < 1)
            q = 1;
        if (q > 65535)
            q = 65535;
        ton_cyc = q[ton_w-1:0];
    end

    // regulation target with limited trim and deep-sleep offset
    logic [mv_w-1:0] next_target_mv;
    always_comb
    begin
        int trim_lim;
        int off;
        int t;
        trim_lim = int'(voltage_code) * trim_pct / 100;
        off = int'(offset_plus_input) - int'(offset_minus_input);
        off = clampi(off, offset_lim_mv);
        t = int'(voltage_code) + clampi(int'(trim_request), trim_lim);
        if (!dsn_q)
            t = t + off;
        if (t < 0)
            t = 0;
        next_target_mv = t[mv_w-1:0];
    end

    // slew clock from resistor: period in clk cycles
    logic [19:0] slew_div, next_slew_div;
    logic next_slew_tick;
    logic [19:0] slew_period;
    always_comb
    begin
        int r;
        int p;
        r = (slew_clock_resistor == '0) ? slew_res_default : int'(slew_clock_resistor);
        // f = 320k*47k/r, so period = clk*r/(320k*47k)
        p = (clk_mhz * 1000 * (r / 100)) / (slew_base_khz * (slew_ref_ohm / 100));
        if (p < 1)
            p = 1;
        slew_period = p[19:0];
        next_slew_tick = (slew_div + 20'h1 >= slew_period);
        next_slew_div = next_slew_tick ? 20'h0 : slew_div + 20'h1;
    end

    // mode edges seen on the filtered pins
    logic sus_d, dsn_d, next_sus_d, next_dsn_d;
    logic mode_chg;
    always_comb
    begin
        next_sus_d = sus_q;
        next_dsn_d = dsn_q;
        mode_chg = (sus_q != sus_d) || (dsn_q != dsn_d);
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sus_d <= 1'b0;
            dsn_d <= 1'b1;
        end
        else
        begin
            sus_d <= next_sus_d;
            dsn_d <= next_dsn_d;
        end
    end

    // settle counter: forced pwm held after code steps and mode changes
    logic [5:0] settle, next_settle;
    logic next_skip;
    always_comb
    begin
        // reload beats the decrement so a late step restarts the wait
        if (code_step || mode_chg)
            next_settle = 6'(settle_slew_cyc);
        else if (slew_tick && settle != 6'h0)
            next_settle = settle - 6'h1;
        else
            next_settle = settle;
        // low-power request only honored after settling
        next_skip = (sus_q || !dsn_q) && settle == 6'h0 && !code_step && !mode_chg;
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            settle <= 6'h0;
            skip_mode <= 1'b0;
        end
        else
        begin
            settle <= next_settle;
            skip_mode <= next_skip;
        end
    end

    // pulse state machine
    cotpwm_state_t state, next_state;
    logic [ton_w-1:0] cnt, next_cnt;
    logic next_hs, next_ls;
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            cotpwm_idle_t_s:
            begin
                if (!ec_q && !cl_q)
                begin
                    next_state = cotpwm_on_s;
                    next_cnt = ton_cyc;
                end
            end
            cotpwm_on_s:
            begin
                if (cnt <= 16'h1)
                begin
                    next_state = cotpwm_off_s;
                    next_cnt = 16'(min_off_cyc);
                end
                else
                    next_cnt = cnt - 16'h1;
            end
            cotpwm_off_s:
            begin
                if (cnt <= 16'h1)
                    next_state = cotpwm_idle_t_s;
                else
                    next_cnt = cnt - 16'h1;
            end
            default:
            begin
                next_state = cotpwm_idle_t_s;
                next_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= cotpwm_idle_t_s;
            cnt <= '0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // drives follow the next state so both leave flops together
    always_comb
    begin
        next_hs = (next_state == cotpwm_on_s);
        // skip mode releases low side; zero-cross comparator is analog
        next_ls = next_skip ? (next_state == cotpwm_off_s) : !next_hs;
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            high_side_drive <= 1'b0;
            low_side_drive <= 1'b1;
        end
        else
        begin
            high_side_drive <= next_hs;
            low_side_drive <= next_ls;
        end
    end

    // target is a level, one cycle late is harmless
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            target_mv <= '0;
        else
            target_mv <= next_target_mv;
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            slew_div <= '0;
            slew_tick <= 1'b0;
        end
        else
        begin
            slew_div <= next_slew_div;
            slew_tick <= next_slew_tick;
        end
    end
endmodule

// *** testbench/cotpwm_core_assertions.sv ***
// Purpose: port checker for cotpwm_core
// Assumes: one clk_sys domain, input filters add a few cycles
// Notes: slack windows allow for the filter delay
`timescale 1ns/1ps
module cotpwm_core_assertions #(
    parameter int slew_res_default = 47000
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic error_comp,
    input wire logic current_limit,
    input wire logic suspend_request,
    input wire logic deep_sleep_n,
    input wire logic code_step,
    input wire logic [19:0] slew_clock_resistor,
    input wire logic high_side_drive,
    input wire logic low_side_drive,
    input wire logic skip_mode,
    input wire logic slew_tick
);
    localparam int tick_cyc = 10000 * (slew_res_default / 100) / (320 * 470);
    logic [7:0] gap;
    logic seen;
    logic [5:0] settle;
    logic lp_mode;
    wire lp = suspend_request || !deep_sleep_n;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    // mode edges restart the count early, so it can overstate the design's
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            gap <= 8'h0;
            seen <= 1'b0;
            settle <= 6'h0;
            lp_mode <= 1'b0;
        end
        else
        begin
            lp_mode <= lp;
            gap <= slew_tick ? 8'h1 : gap + {7'h0, gap != 8'hff};
            seen <= seen | slew_tick;
            if (code_step || lp != lp_mode)
                settle <= 6'h0;
            else if (slew_tick && settle != 6'h3f)
                settle <= settle + 6'h1;
        end
    end
    AST_MIN_OFF: assert property ($fell(high_side_drive) |=> !high_side_drive [*4])
        else $error("high side back on too early");
    AST_COMPLEMENT: assert property ((!skip_mode && !$past(skip_mode)) |-> low_side_drive != high_side_drive)
        else $error("low side not complement");
    AST_LIMIT_HOLD: assert property (current_limit [*6] |-> !$rose(high_side_drive))
        else $error("pulse over current limit");
    AST_COMP_HOLD: assert property (error_comp [*6] |-> !$rose(high_side_drive))
        else $error("pulse with comparator high");
    AST_SKIP_SETTLE: assert property ($rose(skip_mode) |-> settle + slew_tick >= 30)
        else $error("skip before settle count");
    AST_SKIP_NORMAL: assert property ((!lp) [*6] |-> !skip_mode)
        else $error("skip in normal mode");
    AST_CODE_FORCED: assert property (code_step |-> ##2 !skip_mode [*8])
        else $error("skip during code change");
    AST_TICK_GAP: assert property ((slew_tick && seen && slew_clock_resistor == 20'h0)
        |-> gap >= tick_cyc && gap <= tick_cyc + 1)
        else $error("slew tick period");
    AST_TICK_PULSE: assert property (slew_tick |=> !slew_tick)
        else $error("slew tick too long");
endmodule

// *** testbench/cotpwm_switch_model.sv ***
// Purpose: power stage stand-in driving the error comparator
// Assumes: output rises above target once a high pulse is seen
// Notes: demand low keeps the comparator high, so nothing fires
`timescale 1ns/1ps
module cotpwm_switch_model (
    input wire logic clk_sys,
    input wire logic high_side_drive,
    input wire logic demand,
    output logic error_comp
);
    logic served = 1'b0;
    assign error_comp = !(demand && !served);
    always @(negedge clk_sys)
        served <= demand && (served || high_side_drive);
endmodule

// *** testbench/cotpwm_core_tb.sv ***
// Purpose: self-checking bench for cotpwm_core
// Assumes: 10 MHz clk_sys, inputs driven on the falling edge
// Notes: on-times measured in whole cycles of high_side_drive
`timescale 1ns/1ps
module cotpwm_core_tb;
    import cotpwm_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic current_limit = 1'b0;
    logic [1:0] on_time_select = 2'h0;
    logic suspend_request = 1'b0;
    logic deep_sleep_n = 1'b1;
    logic [mv_w-1:0] feedback_sense = 12'h0;
    logic [mv_w-1:0] vin_mv = 12'h3e8;
    logic [mv_w-1:0] voltage_code = 12'h3e8;
    logic signed [mv_w-1:0] trim_request = 12'h0;
    logic [mv_w-1:0] offset_plus_input = 12'h0;
    logic [mv_w-1:0] offset_minus_input = 12'h0;
    logic code_step = 1'b0;
    logic [19:0] slew_res = 20'h0;
    logic demand = 1'b0;
    logic error_comp, high_side_drive, low_side_drive, skip_mode, slew_tick;
    logic [mv_w-1:0] target_mv;
    logic [15:0] lfsr = 16'hb16a;
    int num_errors = 0;
    int tests_run = 0;
    int pulses = 0;
    int width = 0;
    int expq[$];
    int tt[6] = '{50, 200, -200, 0, 0, 300};
    int pp[6] = '{300, 300, 300, 500, 100, 0};
    int mm[6] = '{0, 0, 0, 200, 150, 500};
    int ex[6] = '{1050, 1080, 920, 1200, 950, 880};
    cotpwm_core cotpwm_core_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .error_comp(error_comp),
        .current_limit(current_limit), .on_time_select(on_time_select),
        .suspend_request(suspend_request), .deep_sleep_n(deep_sleep_n),
        .feedback_sense(feedback_sense), .vin_mv(vin_mv), .voltage_code(voltage_code),
        .trim_request(trim_request), .offset_plus_input(offset_plus_input),
        .offset_minus_input(offset_minus_input), .slew_clock_resistor(slew_res),
        .code_step(code_step), .high_side_drive(high_side_drive),
        .low_side_drive(low_side_drive), .skip_mode(skip_mode), .target_mv(target_mv),
        .slew_tick(slew_tick));
    cotpwm_switch_model cotpwm_switch_model_i (.clk_sys(clk_sys),
        .high_side_drive(high_side_drive), .demand(demand), .error_comp(error_comp));
    initial
        forever #50 clk_sys = ~clk_sys;
    function automatic logic [15:0] next_rand(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic check(input bit ok, input string msg);
        tests_run++;
        if (!ok)
        begin
            num_errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic test_done;
        $display("errors %0d, checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // blk holds the current limit first: no pulse may fire meanwhile
    task automatic fire(input logic [1:0] sel, input int fb, input int vin, input bit blk);
        int k;
        int n;
        int base;
        k = sel == sel_vcc ? k_vcc_ns : sel == sel_open ? k_open_ns : sel == sel_ref ? k_ref_ns : k_gnd_ns;
        n = k * (fb + drop_mv) / vin * clk_mhz / 1000;
        if (n < 1)
            n = 1;
        on_time_select = sel;
        feedback_sense = fb[mv_w-1:0];
        vin_mv = vin[mv_w-1:0];
        current_limit = blk;
        demand = 1'b1;
        base = pulses;
        repeat (30 * blk) @(negedge clk_sys);
        check(pulses == base, "pulse while limited");
        current_limit = 1'b0;
        expq.push_back(n);
        repeat (300) if (pulses == base) @(negedge clk_sys);
        check(pulses != base, "no pulse");
        demand = 1'b0;
        repeat (10) @(negedge clk_sys);
    endtask
    always @(negedge clk_sys)
    begin
        if (high_side_drive === 1'b1)
            width++;
        else if (width > 0)
        begin
            pulses++;
            if (expq.size() == 0)
                check(1'b0, "unrequested pulse");
            else
                check(expq.pop_front() == width, "on-time width");
            width = 0;
        end
    end
    initial
    begin
        int n;
        repeat (2) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (6) @(negedge clk_sys);
        for (int i = 0; i < 4; i++)
            fire(2'(i), 925, 1000, i == 2);
        fire(sel_gnd, 0, 4000, 1'b0);
        for (int i = 0; i < 6; i++)
        begin
            lfsr = next_rand(lfsr);
            fire(lfsr[1:0], 100 + lfsr[9:0], 600 + lfsr[15:6], 1'b0);
        end
        for (int i = 0; i < 6; i++)
        begin
            deep_sleep_n = i < 3;
            trim_request = tt[i][mv_w-1:0];
            offset_plus_input = pp[i][mv_w-1:0];
            offset_minus_input = mm[i][mv_w-1:0];
            repeat (10) @(negedge clk_sys);
            check(target_mv === ex[i][mv_w-1:0], "target level");
        end
        for (int m = 0; m < 2; m++)
        begin
            suspend_request = m == 0;
            deep_sleep_n = m == 0;
            code_step = 1'b1;
            @(negedge clk_sys);
            code_step = 1'b0;
            n = 0;
            while (skip_mode !== 1'b1 && n < 1200)
            begin
                @(negedge clk_sys);
                n++;
            end
            check(n >= 29 * 31 && n < 1200, "skip entry time");
            fire(sel_gnd, 925, 1000, 1'b0);
            suspend_request = 1'b0;
            deep_sleep_n = 1'b1;
            repeat (8) @(negedge clk_sys);
            check(skip_mode === 1'b0, "back to forced pwm");
        end
        // 23500 ohm: fast end of the slew clock range
        slew_res = 20'h5bcc;
        repeat (40) @(negedge clk_sys);
        n = 0;
        while (slew_tick !== 1'b1 && n < 100)
        begin
            @(negedge clk_sys);
            n++;
        end
        n = 0;
        do
        begin
            @(negedge clk_sys);
            n++;
        end
        while (slew_tick !== 1'b1 && n < 100);
        check(n == clk_mhz * 1000 * 23500 / (slew_base_khz * slew_ref_ohm), "slew period");
        test_done();
    end
    initial
    begin
        #2ms;
        check(1'b0, "watchdog expired");
        test_done();
    end
endmodule
bind cotpwm_core cotpwm_core_assertions #(.slew_res_default(slew_res_default))
    cotpwm_core_assertions_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .error_comp(error_comp),
    .current_limit(current_limit), .suspend_request(suspend_request),
    .deep_sleep_n(deep_sleep_n), .code_step(code_step),
    .slew_clock_resistor(slew_clock_resistor), .high_side_drive(high_side_drive),
    .low_side_drive(low_side_drive), .skip_mode(skip_mode), .slew_tick(slew_tick));
